// ### design/pol_cfg.svh
// Purpose: Constants for the on/off and three-term loop controller
// Assumes: Byte addresses on an APB bus with 32-bit data
// Notes: Demand is scaled so that POL_DMAX stands for 100 percent
`ifndef POL_CFG_SVH
`define POL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define POL_OFF_CTRL 8'h00
`define POL_OFF_SP1 8'h04
`define POL_OFF_SP2 8'h08
`define POL_OFF_HYST 8'h0C
`define POL_OFF_PBAND 8'h10
`define POL_OFF_TI 8'h14
`define POL_OFF_TD 8'h18
`define POL_OFF_MR 8'h1C
`define POL_OFF_MANPWR 8'h20
`define POL_OFF_CGAIN 8'h24
`define POL_OFF_RLO 8'h28
`define POL_OFF_RHI 8'h2C
`define POL_OFF_STATUS 8'h30

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define POL_CTRL_PID 0
`define POL_CTRL_COOLEN 1
`define POL_CTRL_CURVE 2
`define POL_CTRL_CLEAR 4
`define POL_CTRL_FN 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POL_RST_CTRL 16'h0001
`define POL_RST_HYST 16'h0002
`define POL_RST_PBAND 16'h0005
`define POL_RST_TI 16'h0168
`define POL_RST_TD 16'h003C
`define POL_RST_CGAIN 8'h0A
`define POL_RST_RHI 16'h03E8

// ----------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------
`define POL_DMAX 1000
`define POL_PB_DIV 100
`define POL_GAIN_ONE 10
`define POL_IFRAC 8
`define POL_CLK_MHZ 100
`define POL_SAMPLE_MS 100
`define POL_SPS (1000 / `POL_SAMPLE_MS)
`define POL_TICK_CYCLES (`POL_SAMPLE_MS * 1000 * `POL_CLK_MHZ)

`endif

// ### design/pol_pkg.sv
// Purpose: Types shared by the loop controller and its bench
// Assumes: Nothing beyond the constants header
// Notes: Bus structs keep the published APB signal names
package pol_pkg;

  // Cooling characteristic selection
  typedef enum logic [1:0] {
    POL_COOL_LINEAR = 2'h0,
    POL_COOL_WATER = 2'h1,
    POL_COOL_OIL = 2'h2,
    POL_COOL_FAN = 2'h3
  } pol_cool_curve_type;

  // Function assigned to a contact input
  typedef enum logic [3:0] {
    POL_FN_NONE = 4'h0,
    POL_FN_ALARM_ACK = 4'h1,
    POL_FN_SP2_SEL = 4'h2,
    POL_FN_KEY_LOCK = 4'h3,
    POL_FN_TMR_RESET = 4'h4,
    POL_FN_TMR_RUN = 4'h5,
    POL_FN_TMR_RUNRST = 4'h6,
    POL_FN_TMR_HOLD = 4'h7,
    POL_FN_MANUAL = 4'h8,
    POL_FN_STANDBY = 4'h9
  } pol_contact_fn_type;

  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } pol_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pol_apb_rsp_type;

  // Actuator drive: on/off levels and demand in 0..POL_DMAX
  typedef struct packed {
    logic heatOn;
    logic coolOn;
    logic [10:0] heatDemand;
    logic [10:0] coolDemand;
  } pol_drive_type;

endpackage : pol_pkg

// ### design/pol_loop_control.sv
// Purpose: On/off and three-term temperature loop with APB registers
// Assumes: processValue comes from logic on clk; contact pins are asynchronous
// Notes: Drive and integral update on the sample tick; a soft clear zeroes the integral in any cycle
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pol_cfg.svh"

// Functional notes
// - On/off: heat on below, off above setpoint
// - On/off cooling: on above, off below setpoint
// - Hysteresis band stops on/off chatter
// - Three-term demand is P plus I plus D
// - Integral and derivative switch off independently
// - Heat demand linear 0-100 across band
// - Below band full heat, above band none
// - Band set as percent of range
// - Below setpoint integral raises demand
// - Above setpoint integral lowers heat, raises cool
// - Integral time 1-9999 s, zero means off; the register takes any value up to 65535
// - Derivative time zero gives no derivative
// - Derivative taken on process value only
// - Selectable linear, water, oil, fan cooling
// - Cooling band is heat band scaled by gain
// - Tuning run writes relative cooling gain
// - Each contact input takes one function
// - Integral off adds manual reset power
module pol_loop_control #(
  parameter int unsigned TICK_CYCLES = `POL_TICK_CYCLES,
  parameter int unsigned NUM_CONTACTS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire pol_pkg::pol_apb_req_type apbReq,
  output pol_pkg::pol_apb_rsp_type apbRsp,
  // Sensor and tuning
  input wire logic signed [15:0] processValue,
  input wire logic tuneDone,
  input wire logic [7:0] tuneCoolGain,
  // Contact pins
  input wire logic contactInputA,
  input wire logic contactInputB,
  // Actuators and contact functions
  output pol_pkg::pol_drive_type drive,
  output logic [8:0] contactFuncs
);
  import pol_pkg::*;

  localparam logic signed [47:0] DMAXW = 48'(`POL_DMAX);
  localparam logic signed [47:0] SPSW = 48'(`POL_SPS);
  localparam logic signed [47:0] PBDIVW = 48'(`POL_PB_DIV);
  localparam logic signed [47:0] GONEW = 48'(`POL_GAIN_ONE);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic softClear_r;
  logic signed [15:0] setpointValue1_r, setpointValue2_r, rangeLo_r, rangeHi_r;
  logic signed [15:0] zeroErrorPowerOffset_r, manualPower_r;
  logic [15:0] hyst_r, propBandWidth_r, integralTime_r, rateTimeSetting_r;
  logic [7:0] coolGain_r;
  logic [31:0] rdata_r, rdNxt;
  logic addrHit;
  logic [31:0] tickCnt_r;
  logic sampleTick;
  logic signed [47:0] integAcc_r, pvPrev_r;
  pol_drive_type drive_r;
  logic [8:0] contactFuncs_r;
  logic [NUM_CONTACTS-1:0] pins, pinLevel_r;
  logic [8:0] hitAcc [0:NUM_CONTACTS];

  wire logic wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
  wire logic pidMode = ctrl_r[`POL_CTRL_PID];
  wire logic coolEn = ctrl_r[`POL_CTRL_COOLEN];
  wire pol_cool_curve_type curve = pol_cool_curve_type'(ctrl_r[`POL_CTRL_CURVE +: 2]);
  wire logic sp2Sel = contactFuncs_r[int'(POL_FN_SP2_SEL) - 1];
  wire logic manualSel = contactFuncs_r[int'(POL_FN_MANUAL) - 1];
  wire logic standbySel = contactFuncs_r[int'(POL_FN_STANDBY) - 1];

  // ----------------------------------------------------------------
  // APB slave: zero wait states, data registered in setup phase
  // ----------------------------------------------------------------
  always_comb begin
    addrHit = 1'b1;
    rdNxt = 32'h0000_0000;
    case (apbReq.paddr)
      `POL_OFF_CTRL: rdNxt = {16'h0000, ctrl_r};
      `POL_OFF_SP1: rdNxt = 32'(setpointValue1_r);
      `POL_OFF_SP2: rdNxt = 32'(setpointValue2_r);
      `POL_OFF_HYST: rdNxt = {16'h0000, hyst_r};
      `POL_OFF_PBAND: rdNxt = {16'h0000, propBandWidth_r};
      `POL_OFF_TI: rdNxt = {16'h0000, integralTime_r};
      `POL_OFF_TD: rdNxt = {16'h0000, rateTimeSetting_r};
      `POL_OFF_MR: rdNxt = 32'(zeroErrorPowerOffset_r);
      `POL_OFF_MANPWR: rdNxt = 32'(manualPower_r);
      `POL_OFF_CGAIN: rdNxt = {24'h000000, coolGain_r};
      `POL_OFF_RLO: rdNxt = 32'(rangeLo_r);
      `POL_OFF_RHI: rdNxt = 32'(rangeHi_r);
      `POL_OFF_STATUS: rdNxt = {pinLevel_r[1:0], drive_r.coolOn, drive_r.heatOn, 1'b0,
                                drive_r.coolDemand, 5'h00, drive_r.heatDemand};
      default: addrHit = 1'b0;
    endcase
  end

  // Read data captured while the request is in setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (apbReq.psel && !apbReq.penable) begin
      rdata_r <= rdNxt;
    end
  end

  assign apbRsp = '{prdata: rdata_r, pready: 1'b1,
                    pslverr: apbReq.psel & apbReq.penable & ~addrHit};

  // Configuration writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `POL_RST_CTRL;
      softClear_r <= 1'b0;
      setpointValue1_r <= 16'h0000;
      setpointValue2_r <= 16'h0000;
      hyst_r <= `POL_RST_HYST;
      propBandWidth_r <= `POL_RST_PBAND;
      integralTime_r <= `POL_RST_TI;
      rateTimeSetting_r <= `POL_RST_TD;
      zeroErrorPowerOffset_r <= 16'h0000;
      manualPower_r <= 16'h0000;
      rangeLo_r <= 16'h0000;
      rangeHi_r <= `POL_RST_RHI;
    end else begin
      softClear_r <= wrEn && apbReq.paddr == `POL_OFF_CTRL &&
                     apbReq.pwdata[`POL_CTRL_CLEAR];
      if (wrEn) begin
        case (apbReq.paddr)
          `POL_OFF_CTRL: ctrl_r <= apbReq.pwdata[15:0] & 16'hFFEF;
          `POL_OFF_SP1: setpointValue1_r <= apbReq.pwdata[15:0];
          `POL_OFF_SP2: setpointValue2_r <= apbReq.pwdata[15:0];
          `POL_OFF_HYST: hyst_r <= apbReq.pwdata[15:0];
          `POL_OFF_PBAND: propBandWidth_r <= apbReq.pwdata[15:0];
          `POL_OFF_TI: integralTime_r <= apbReq.pwdata[15:0];
          `POL_OFF_TD: rateTimeSetting_r <= apbReq.pwdata[15:0];
          `POL_OFF_MR: zeroErrorPowerOffset_r <= apbReq.pwdata[15:0];
          `POL_OFF_MANPWR: manualPower_r <= apbReq.pwdata[15:0];
          `POL_OFF_RLO: rangeLo_r <= apbReq.pwdata[15:0];
          `POL_OFF_RHI: rangeHi_r <= apbReq.pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Cooling gain: a finished tuning run overrides a bus write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coolGain_r <= `POL_RST_CGAIN;
    end else if (tuneDone) begin
      coolGain_r <= tuneCoolGain;
    end else if (wrEn && apbReq.paddr == `POL_OFF_CGAIN) begin
      coolGain_r <= apbReq.pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Contact inputs: synchronise, then decode assigned function
  // ----------------------------------------------------------------
  assign pins = {contactInputB, contactInputA};
  assign hitAcc[0] = 9'h000;

  for (genvar g = 0; g < NUM_CONTACTS; g++) begin : gContact
    logic meta_r;
    logic [8:0] hit;
    wire logic [3:0] fnSel = ctrl_r[`POL_CTRL_FN + 4 * g +: 4];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_r <= 1'b0;
        pinLevel_r[g] <= 1'b0;
      end else begin
        meta_r <= pins[g];
        pinLevel_r[g] <= meta_r;
      end
    end
    // One-hot function for this input while it is closed
    assign hit = (pinLevel_r[g] && fnSel != 4'h0 && fnSel <= 4'(POL_FN_STANDBY)) ?
                 9'(9'h001 << (fnSel - 4'h1)) : 9'h000;
    assign hitAcc[g + 1] = hitAcc[g] | hit;
  end

  // Registered function levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contactFuncs_r <= 9'h000;
    end else begin
      contactFuncs_r <= hitAcc[NUM_CONTACTS];
    end
  end
  assign contactFuncs = contactFuncs_r;

  // ----------------------------------------------------------------
  // Sample tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickCnt_r <= 32'h0000_0000;
    end else begin
      tickCnt_r <= (tickCnt_r == TICK_LAST) ? 32'h0000_0000 : tickCnt_r + 32'h0000_0001;
    end
  end
  assign sampleTick = (tickCnt_r == TICK_LAST);

  // ----------------------------------------------------------------
  // Control arithmetic
  // ----------------------------------------------------------------
  function automatic logic signed [47:0] sat(input logic signed [47:0] x,
                                             input logic signed [47:0] lim);
    if (x > lim) return lim;
    if (x < -lim) return -lim;
    return x;
  endfunction : sat

  logic signed [47:0] pvNow, spNow, pbEng, errW, pTerm, iTerm, dTerm, total;
  logic signed [47:0] accNxt, coolLin, coolOut, hHalf;
  logic signed [47:0] tiW, tdW, gainW;

  always_comb begin
    pvNow = 48'(processValue);
    spNow = sp2Sel ? 48'(setpointValue2_r) : 48'(setpointValue1_r);
    tiW = {32'h0000_0000, integralTime_r};
    tdW = {32'h0000_0000, rateTimeSetting_r};
    gainW = {40'h00_0000_0000, coolGain_r};
    hHalf = {32'h0000_0000, hyst_r} >>> 1;
    // Band in process units from percent of span
    pbEng = (48'(rangeHi_r) - 48'(rangeLo_r)) * {32'h0000_0000, propBandWidth_r} / PBDIVW;
    if (pbEng < 48'sd1) begin
      pbEng = 48'sd1;
    end
    errW = spNow - pvNow;
    pTerm = sat(errW * DMAXW / pbEng, DMAXW);
    // Integral accumulates the proportional term, scaled by time
    if (integralTime_r == 16'h0000) begin
      accNxt = 48'sd0;
      iTerm = 48'(zeroErrorPowerOffset_r);
    end else begin
      accNxt = sat(integAcc_r + (pTerm <<< `POL_IFRAC) / (tiW * SPSW),
                   DMAXW <<< `POL_IFRAC);
      iTerm = integAcc_r >>> `POL_IFRAC;
    end
    // Derivative on process value so setpoint steps do not kick
    if (rateTimeSetting_r == 16'h0000) begin
      dTerm = 48'sd0;
    end else begin
      dTerm = sat(-((pvNow - pvPrev_r) * DMAXW * tdW * SPSW) / pbEng, DMAXW);
    end
    total = sat(pTerm + iTerm + dTerm, DMAXW);
    // Cooling band narrowed or widened by the relative gain
    coolLin = (total < 48'sd0) ? sat(-total * gainW / GONEW, DMAXW) : 48'sd0;
    case (curve)
      POL_COOL_WATER: coolOut = coolLin * coolLin / DMAXW;
      POL_COOL_OIL: coolOut = (coolLin + coolLin * coolLin / DMAXW) >>> 1;
      POL_COOL_FAN: coolOut = (48'sd3 * coolLin - coolLin * coolLin / DMAXW) >>> 1;
      default: coolOut = coolLin;
    endcase
  end

  // Integral state and previous process value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      integAcc_r <= 48'sd0;
      pvPrev_r <= 48'sd0;
    end else if (softClear_r) begin
      integAcc_r <= 48'sd0;
    end else if (sampleTick) begin
      pvPrev_r <= pvNow;
      if (pidMode && !manualSel && !standbySel) begin
        integAcc_r <= accNxt;
      end else begin
        integAcc_r <= 48'sd0;
      end
    end
  end

  // Actuator update once per tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_r <= '0;
    end else if (sampleTick) begin
      if (standbySel) begin
        drive_r <= '0;
      end else if (manualSel) begin
        drive_r.heatDemand <= 11'(manualPower_r > 0 ? sat(48'(manualPower_r), DMAXW) : 48'sd0);
        drive_r.coolDemand <= 11'(manualPower_r < 0 ? sat(-48'(manualPower_r), DMAXW) : 48'sd0);
        drive_r.heatOn <= manualPower_r > 0;
        drive_r.coolOn <= manualPower_r < 0;
      end else if (pidMode) begin
        drive_r.heatDemand <= 11'((total > 48'sd0) ? total : 48'sd0);
        drive_r.coolDemand <= coolEn ? 11'(coolOut) : 11'h000;
        drive_r.heatOn <= total > 48'sd0;
        drive_r.coolOn <= coolEn && coolOut > 48'sd0;
      end else begin
        // Switch only outside the band; inside it the output holds
        if (pvNow < spNow - hHalf) begin
          drive_r.heatOn <= 1'b1;
          drive_r.heatDemand <= 11'(DMAXW);
        end else if (pvNow > spNow + hHalf) begin
          drive_r.heatOn <= 1'b0;
          drive_r.heatDemand <= 11'h000;
        end
        if (!coolEn || pvNow < spNow - hHalf) begin
          drive_r.coolOn <= 1'b0;
          drive_r.coolDemand <= 11'h000;
        end else if (pvNow > spNow + hHalf) begin
          drive_r.coolOn <= 1'b1;
          drive_r.coolDemand <= 11'(DMAXW);
        end
      end
    end
  end
  assign drive = drive_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire logic autoRun = sampleTick && !standbySel && !manualSel;
  wire logic pOnly = integralTime_r == 16'h0000 && rateTimeSetting_r == 16'h0000 &&
                     zeroErrorPowerOffset_r == 16'h0000;

  onoff_heat_on_a: assert property (autoRun && !pidMode && pvNow < spNow - hHalf
    |=> drive.heatOn && drive.heatDemand == 11'(DMAXW)) else $error("heat not on");
  onoff_cool_on_a: assert property (autoRun && !pidMode && coolEn && pvNow > spNow + hHalf
    |=> drive.coolOn ##1 drive.coolOn || sampleTick) else $error("cool not on");
  onoff_hyst_hold_a: assert property (autoRun && !pidMode && pvNow >= spNow - hHalf &&
    pvNow <= spNow + hHalf |=> $stable(drive.heatOn)) else $error("chatter in band");
  band_saturate_a: assert property (autoRun && pidMode && pOnly && errW >= pbEng
    |=> drive.heatDemand == 11'(DMAXW)) else $error("no full heat below band");
  band_linear_a: assert property (autoRun && pidMode && pOnly && errW >= 0 && errW < pbEng
    |=> drive.heatDemand == 11'($past(errW) * DMAXW / $past(pbEng)))
    else $error("demand not linear");
  demand_clamp_a: assert property (drive.heatDemand <= 11'(DMAXW) &&
    drive.coolDemand <= 11'(DMAXW)) else $error("demand out of range");
  deriv_off_a: assert property (rateTimeSetting_r == 16'h0000 |-> dTerm == 48'sd0)
    else $error("derivative while off");
  deriv_pv_only_a: assert property (pvNow == pvPrev_r |-> dTerm == 48'sd0)
    else $error("derivative from setpoint");
  integ_off_a: assert property (sampleTick && integralTime_r == 16'h0000
    |=> integAcc_r == 48'sd0 && iTerm == 48'(zeroErrorPowerOffset_r))
    else $error("integral not off");
  soft_clear_a: assert property (softClear_r |=> integAcc_r == 48'sd0)
    else $error("integral not cleared");
  tune_gain_a: assert property (tuneDone |=> coolGain_r == $past(tuneCoolGain))
    else $error("gain not written by tuning");
  integ_rise_a: assert property (autoRun && pidMode && integralTime_r != 16'h0000 &&
    errW > 0 && integAcc_r <= 48'sd0 |=> integAcc_r >= $past(integAcc_r))
    else $error("integral fell below setpoint");

  heat_cycle_c: cover property (drive.heatOn ##[1:1000] !drive.heatOn);
  cool_pid_c: cover property (pidMode && drive.coolDemand != 11'h000);
  standby_c: cover property (standbySel && sampleTick);
  sp2_c: cover property (sp2Sel ##1 sampleTick);

endmodule : pol_loop_control
`default_nettype wire

// ### test/pol_plant.sv
// Purpose: Plant model giving the temperature sensor reading
// Assumes: The bench commands the temperature the sensor should report
// Notes: Actuator drive is absorbed; the sensor lags the command by one clock
`timescale 1ns/10ps
`default_nettype none
module pol_plant (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Actuator drive from the controller
  input wire pol_pkg::pol_drive_type drive,
  // Commanded temperature
  input wire logic signed [15:0] newPv,
  // Sensor reading
  output logic signed [15:0] processValue
);
  import pol_pkg::*;
  // ----------------------------------------------------------------
  // Sensor register
  // ----------------------------------------------------------------
  // One clock of sensor delay, cleared while in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      processValue <= 16'sh0000;
    end else begin
      processValue <= newPv;
    end
  end
endmodule : pol_plant
`default_nettype wire

// ### test/pol_loop_control_test.sv
// Purpose: Self-checking bench for the loop controller
// Assumes: Tick shortened to 16 clocks; bench counter mirrors the tick
// Notes: Expected results are queued and compared by a watcher process
`timescale 1ns/10ps
`default_nettype none
`include "pol_cfg.svh"
module pol_loop_control_test;
  import pol_pkg::*;
  typedef struct packed {logic [1:0] kind; logic [32:0] val; logic [32:0] mask;} pol_exp_type;
  localparam int TICK = 16;
  localparam logic [32:0] FULL = 33'h0FFFFFF;
  localparam logic [32:0] HM = 33'h03FF800;
  localparam logic [32:0] DM = 33'h03FFFFF;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pol_apb_req_type apbReq = '0;
  pol_apb_rsp_type apbRsp;
  logic signed [15:0] newPv = 16'sh0000;
  logic signed [15:0] pv;
  logic tuneDone = 1'b0;
  logic [7:0] tuneCoolGain = 8'h00;
  logic cA = 1'b0;
  logic cB = 1'b0;
  pol_drive_type drive;
  logic [8:0] contactFuncs;
  logic probe = 1'b0;
  logic [3:0] cnt;
  pol_exp_type expQ[$];
  pol_exp_type e;
  logic [32:0] seen;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 32'hd178;
  int i, pvr, ev;
  logic bRand;
  logic [7:0] regA[8] = '{`POL_OFF_CTRL, `POL_OFF_HYST, `POL_OFF_PBAND, `POL_OFF_TI,
                          `POL_OFF_TD, `POL_OFF_CGAIN, `POL_OFF_RLO, `POL_OFF_RHI};
  logic [31:0] regV[8] = '{`POL_RST_CTRL, `POL_RST_HYST, `POL_RST_PBAND, `POL_RST_TI,
                           `POL_RST_TD, `POL_RST_CGAIN, 32'h0, `POL_RST_RHI};
  int pvs[7] = '{480, 495, 505, 520, 505, 495, 480};
  logic [1:0] hc[7] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2};
  int curv[4] = '{400, 160, 280, 520};

  // ----------------------------------------------------------------
  // Clock, design and plant
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  pol_loop_control #(.TICK_CYCLES(TICK), .NUM_CONTACTS(2)) dut (.clk(clk), .rst(rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .processValue(pv), .tuneDone(tuneDone),
    .tuneCoolGain(tuneCoolGain), .contactInputA(cA), .contactInputB(cB),
    .drive(drive), .contactFuncs(contactFuncs));
  pol_plant plant (.clk(clk), .rst(rst), .drive(drive), .newPv(newPv), .processValue(pv));
  // Mirror of the sample tick counter
  always @(posedge clk or posedge rst) begin
    if (rst) cnt <= 4'h0;
    else cnt <= (cnt == 4'hF) ? 4'h0 : cnt + 4'h1;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task chk(input logic [32:0] s, input logic [32:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task wrap_up;
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Watcher takes the oldest note when a read or probe result appears
  always @(posedge clk) begin
    if (!rst && (probe || (apbReq.psel && apbReq.penable && !apbReq.pwrite))) begin
      e = expQ.pop_front();
      case (e.kind)
        2'h0: seen = {9'h0, drive};
        2'h1: seen = {24'h0, contactFuncs};
        default: seen = {apbRsp.pslverr, apbRsp.prdata};
      endcase
      chk(seen & e.mask, e.val);
    end
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task note(input logic [1:0] k, input logic [32:0] v, input logic [32:0] m);
    expQ.push_back('{kind: k, val: v, mask: m});
    if (k != 2'h2) begin
      @(posedge clk) probe <= 1'b1;
      @(posedge clk) probe <= 1'b0;
    end
  endtask : note
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.paddr <= a;
    apbReq.pwrite <= w;
    apbReq.pwdata <= d;
    @(posedge clk) apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] v);
    note(2'h2, v, ALL);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task setPv(input int v);
    @(posedge clk) newPv <= v[15:0];
  endtask : setPv
  task waitTicks(input int n);
    repeat (n) begin
      do begin
        @(posedge clk);
        #1;
      end while (cnt != 4'h0);
    end
  endtask : waitTicks
  function automatic logic [32:0] dv(input logic h, input logic c, input int hd, input int cd);
    dv = {9'h0, h, c, hd[10:0], cd[10:0]};
  endfunction : dv

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place, self-clearing bit
    for (i = 0; i < 8; i++) rd(regA[i], {1'b0, regV[i]});
    rd(8'h34, {1'b1, 32'h0});
    wr(`POL_OFF_CTRL, 32'h11);
    rd(`POL_OFF_CTRL, 33'h1);
    // On/off with cooling and hysteresis
    wr(`POL_OFF_CTRL, 32'h2);
    wr(`POL_OFF_SP1, 32'h1F4);
    wr(`POL_OFF_HYST, 32'h14);
    for (i = 0; i < 7; i++) begin
      setPv(pvs[i]);
      waitTicks(2);
      note(2'h0, dv(hc[i][1], hc[i][0], hc[i][1] ? 1000 : 0, hc[i][0] ? 1000 : 0), FULL);
    end
    // Proportional only, band edges and random points within 48 of the setpoint
    wr(`POL_OFF_CTRL, 32'h1);
    wr(`POL_OFF_TI, 32'h0);
    wr(`POL_OFF_TD, 32'h0);
    for (i = 0; i < 7; i++) begin
      pvr = (i == 0) ? 440 : (i == 1) ? 560 : (i == 2) ? 475 : 500 + $random(seed) % 49;
      ev = ((500 - pvr) * 1000) / 50;
      setPv(pvr);
      waitTicks(2);
      note(2'h0, dv(0, 0, (ev < 0) ? 0 : (ev > 1000) ? 1000 : ev, 0), HM);
    end
    wr(`POL_OFF_MR, 32'h64);
    setPv(500);
    waitTicks(2);
    note(2'h0, dv(0, 0, 100, 0), HM);
    wr(`POL_OFF_MR, 32'h0);
    wr(`POL_OFF_RHI, 32'h7D0);
    setPv(475);
    waitTicks(2);
    note(2'h0, dv(0, 0, 250, 0), HM);
    wr(`POL_OFF_RHI, 32'h3E8);
    // Cooling characteristics and gain
    setPv(520);
    for (i = 0; i < 4; i++) begin
      wr(`POL_OFF_CTRL, 32'h3 | (i << 2));
      waitTicks(2);
      note(2'h0, dv(0, 0, 0, curv[i]), DM);
    end
    wr(`POL_OFF_CTRL, 32'h3);
    wr(`POL_OFF_CGAIN, 32'h14);
    waitTicks(2);
    note(2'h0, dv(0, 0, 0, 800), DM);
    @(posedge clk) begin
      tuneDone <= 1'b1;
      tuneCoolGain <= 8'h05;
    end
    @(posedge clk) tuneDone <= 1'b0;
    rd(`POL_OFF_CGAIN, 33'h5);
    waitTicks(2);
    note(2'h0, dv(0, 0, 0, 200), DM);
    // Derivative on process value, no kick from a setpoint step
    wr(`POL_OFF_CTRL, 32'h1);
    wr(`POL_OFF_TD, 32'h1);
    setPv(500);
    waitTicks(2);
    wr(`POL_OFF_SP1, 32'h208);
    waitTicks(1);
    note(2'h0, dv(0, 0, 400, 0), HM);
    setPv(499);
    waitTicks(1);
    note(2'h0, dv(0, 0, 620, 0), HM);
    waitTicks(1);
    note(2'h0, dv(0, 0, 420, 0), HM);
    // Integral winds up below setpoint and down above it
    wr(`POL_OFF_TD, 32'h0);
    wr(`POL_OFF_TI, 32'h1);
    wr(`POL_OFF_SP1, 32'h1F4);
    setPv(490);
    waitTicks(60);
    note(2'h0, dv(0, 0, 1000, 0), HM);
    wr(`POL_OFF_CTRL, 32'h3);
    setPv(510);
    waitTicks(110);
    // Full cooling demand scaled by the tuned gain of one half
    note(2'h0, dv(0, 0, 0, 500), DM);
    // Reset in mid-run clears drive and returns the integral time register to its reset value
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    note(2'h0, 33'h0, FULL);
    rd(`POL_OFF_TI, {1'b0, 32'(`POL_RST_TI)});
    // Contact input functions, codes 1 to 9 on pin A
    for (i = 1; i < 10; i++) begin
      bRand = $random(seed) & 1;
      wr(`POL_OFF_CTRL, 32'h1 | (i << 8) | ((10 - i) << 12));
      @(posedge clk) begin
        cA <= 1'b1;
        cB <= bRand;
      end
      repeat (4) @(posedge clk);
      note(2'h1, (33'h1 << (i - 1)) | (bRand ? 33'h1 << (9 - i) : 33'h0), 33'h1FF);
      @(posedge clk) begin
        cA <= 1'b0;
        cB <= 1'b0;
      end
      repeat (4) @(posedge clk);
    end
    // Second setpoint, manual power and standby chosen by contact A
    wr(`POL_OFF_TI, 32'h0);
    wr(`POL_OFF_TD, 32'h0);
    wr(`POL_OFF_SP2, 32'h21C);
    wr(`POL_OFF_MANPWR, 32'hFFFF_FED4);
    wr(`POL_OFF_CTRL, 32'h201);
    @(posedge clk) cA <= 1'b1;
    waitTicks(2);
    note(2'h0, dv(1, 0, 600, 0), FULL);
    wr(`POL_OFF_CTRL, 32'h801);
    waitTicks(2);
    note(2'h0, dv(0, 1, 0, 300), FULL);
    wr(`POL_OFF_CTRL, 32'h901);
    waitTicks(2);
    note(2'h0, 33'h0, FULL);
    wrap_up();
  end
endmodule : pol_loop_control_test
`default_nettype wire
